// ---- include/pmic_ctrl_map.svh ----
`ifndef PMIC_CTRL_MAP_SVH
`define PMIC_CTRL_MAP_SVH
// Overview of operation
// - Step-up regulator turns on from its register enable only, never a pin.
// - Bucks and buck-boost run when their pin or register enable is set.
// - When the last regulator turns off, all command registers return to defaults.
// - Enable threshold select is high while all off, low once any is on.
// - Paired adjacent bucks: lower number is master; sensed by feedback tied high.
// - Paired bucks use master settings; slave register contents have no effect.
// - Paired bucks start and stop on master enable; slave pin is ignored.
// - Pairs 1-2, 2-3 and 3-4 all follow the same master-slave scheme.
// - Disabled buck switch node floats or pulls down as its control bit says.
// - Mode, feedback setting and slew of each regulator come from registers.
// - Buck-boost below start-up level: no burst, output switch D held off.
// - LED code is zero at power-up; driver stays off until nonzero code.
// - After nonzero code, current ramps to target at gradation rate, then holds.
// - New code while active ramps up or down at rate to new target.
// - Code zero ramps down; at zero boost and LED driver shut down.
// - A register bit sets the LED high-voltage boost mode output; LED boost on still follows the LED code.
// - Fault conditions readable as two status bytes.
// - Written command values read back; pull-down keeps only bits 3:0, LED config only bits 2:0.

// ==========================================
// Register offsets
`define ADDR_BUCK1_CFG   8'h00
`define ADDR_BOOST_CFG   8'h04
`define ADDR_BB_CFG      8'h05
`define ADDR_PULLDOWN    8'h06
`define ADDR_LED_CFG     8'h07
`define ADDR_LED_CODE    8'h08
`define ADDR_FAULT_LO    8'h09
`define ADDR_FAULT_HI    8'h0a
`define ADDR_IRQ_STAT    8'h0b
`define ADDR_IRQ_CLR     8'h0c
`define ADDR_IRQ_EN      8'h0d
`define ADDR_LED_NOW     8'h0e
`define ADDR_STATE       8'h0f

// ==========================================
// Field positions of a regulator config byte and of the LED config byte
`define CFG_FB_LSB       0
`define CFG_SLEW_LSB     4
`define CFG_BURST_BIT    6
`define CFG_EN_BIT       7
`define LED_RATE_LSB     0
`define LED_HV_BIT       2

// ==========================================
// Reset values
`define CFG_RST          8'h00
`define PULLDOWN_RST     4'h0
`define LED_CFG_RST      3'h0
`define LED_CODE_RST     8'h00

// ==========================================
// Timing
`define CLK_MHZ          125
`define LED_STEP_US      1
`define LED_STEP_CYCLES  (`LED_STEP_US * `CLK_MHZ)
`endif

// ---- include/pmic_ctrl_pkg.sv ----
package pmic_ctrl_pkg;
    typedef struct packed {
        logic       burst;
        logic [1:0] slew;
        logic [3:0] fb;
    } reg_set_t;

    typedef enum logic [1:0] {
        LED_OFF,
        LED_RAMP,
        LED_HOLD
    } led_state_t;
endpackage

// ---- design/pmic_ctrl.sv ----
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/10ps
`include "pmic_ctrl_map.svh"
module pmic_ctrl #(
    parameter int STEP_CYCLES = `LED_STEP_CYCLES
) (
    // Clock and reset
    input  wire logic                         core_clk_i,
    input  wire logic                         reset_i,
    // Register port
    input  wire logic [7:0]                   addr_i,
    input  wire logic [7:0]                   wdata_i,
    input  wire logic                         wr_i,
    input  wire logic                         rd_i,
    output logic      [7:0]                   rdata_o,
    // Enable pins and pairing sense
    input  wire logic [3:0]                   buck_en_pin_i,
    input  wire logic                         bb_en_pin_i,
    input  wire logic [2:0]                   pair_sense_i,
    // Analog status
    input  wire logic                         bb_startup_low_i,
    input  wire logic [15:0]                  fault_i,
    // Regulator controls
    output logic      [3:0]                   buck_on_o,
    output logic      [3:0]                   switch_node_pulldown_o,
    output logic                              boost_on_o,
    output logic                              bb_on_o,
    output logic                              bb_switch_d_off_o,
    output pmic_ctrl_pkg::reg_set_t [5:0]     reg_set_o,
    output logic                              en_thresh_low_o,
    // LED driver
    output logic      [7:0]                   led_current_code_o,
    output logic                              led_boost_on_o,
    output logic                              led_hv_mode_o,
    // Interrupt
    output logic                              irq_o
);
    import pmic_ctrl_pkg::*;

    // ==========================================
    // Register state
    logic [7:0]  cfg_reg [6];
    logic [3:0]  pulldown_reg;
    logic [2:0]  led_cfg_reg;
    logic [7:0]  led_code_reg;
    logic [7:0]  irq_stat_reg;
    logic [7:0]  irq_en_reg;
    logic [5:0]  fault_prev_reg;
    logic        any_on_reg;
    logic [7:0]  rdata_reg;

    logic        wr_cfg;
    logic        wr_led_cfg;
    logic        wr_led_code;
    logic        defaults_now;
    logic        any_on;
    logic [7:0]  events;

    // ==========================================
    // Per-buck effective enable and settings
    logic        eff_en   [4];
    reg_set_t    eff_set  [4];
    logic        eff_pd   [4];
    logic        own_en   [4];

    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_buck
            assign own_en[i] = buck_en_pin_i[i] | cfg_reg[i][`CFG_EN_BIT];
            if (i == 0) begin : g_first
                assign eff_en[i]  = own_en[i];
                assign eff_set[i] = reg_set_t'(cfg_reg[i][6:0]);
                assign eff_pd[i]  = pulldown_reg[i];
            end else begin : g_next
                // Slave follows master; its own pin and bits are ignored
                assign eff_en[i]  = pair_sense_i[i-1] ? eff_en[i-1] : own_en[i];
                assign eff_set[i] = pair_sense_i[i-1] ? eff_set[i-1]
                                                      : reg_set_t'(cfg_reg[i][6:0]);
                assign eff_pd[i]  = pair_sense_i[i-1] ? eff_pd[i-1] : pulldown_reg[i];
            end
        end
    endgenerate

    // ==========================================
    // Step-up and buck-boost enables
    logic        boost_en;
    logic        bb_en;
    reg_set_t    bb_set;

    assign boost_en = cfg_reg[4][`CFG_EN_BIT];
    assign bb_en    = bb_en_pin_i | cfg_reg[5][`CFG_EN_BIT];

    // Start-up guard clears only the mode bit; fb and slew pass through
    always_comb begin
        bb_set = reg_set_t'(cfg_reg[5][6:0]);
        if (bb_startup_low_i) begin
            bb_set.burst = 1'b0;
        end
    end

    assign any_on = eff_en[0] | eff_en[1] | eff_en[2] | eff_en[3] | boost_en | bb_en;

    // Defaults are reloaded when the last regulator turns off; a host
    // may still set up fields while everything is off.
    assign defaults_now = any_on_reg & ~any_on;

    // ==========================================
    // Write decode
    assign wr_cfg      = wr_i & (addr_i <= `ADDR_BB_CFG);
    assign wr_led_cfg  = wr_i & (addr_i == `ADDR_LED_CFG);
    assign wr_led_code = wr_i & (addr_i == `ADDR_LED_CODE);

    // Last cycle's any_on, so the reload fires once as the last one turns off
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            any_on_reg <= 1'b0;
        end else begin
            any_on_reg <= any_on;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            for (int k = 0; k < 6; k++) begin
                cfg_reg[k] <= `CFG_RST;
            end
        end else begin
            for (int k = 0; k < 6; k++) begin
                // A host write in the reload cycle wins over the defaults
                if (wr_cfg && addr_i[2:0] == 3'(k)) begin
                    cfg_reg[k] <= wdata_i;
                end else if (defaults_now) begin
                    cfg_reg[k] <= `CFG_RST;
                end
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            pulldown_reg <= `PULLDOWN_RST;
        end else if (wr_i && addr_i == `ADDR_PULLDOWN) begin
            pulldown_reg <= wdata_i[3:0];
        end else if (defaults_now) begin
            pulldown_reg <= `PULLDOWN_RST;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            led_cfg_reg <= `LED_CFG_RST;
        end else if (wr_led_cfg) begin
            led_cfg_reg <= wdata_i[2:0];
        end else if (defaults_now) begin
            led_cfg_reg <= `LED_CFG_RST;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            led_code_reg <= `LED_CODE_RST;
        end else if (wr_led_code) begin
            led_code_reg <= wdata_i;
        end else if (defaults_now) begin
            led_code_reg <= `LED_CODE_RST;
        end
    end

    // ==========================================
    // LED gradation
    led_state_t  led_state;
    logic [7:0]  led_now_reg;
    logic [31:0] step_cnt_reg;
    logic [31:0] step_period;
    logic        step_tick;
    logic [1:0]  rate;

    assign rate = led_cfg_reg[`LED_RATE_LSB +: 2];
    // Each rate step is four times slower than the one below it
    assign step_period = 32'(STEP_CYCLES) << {rate, 1'b0};
    // Counter idles outside a ramp, so every ramp starts with a full step
    assign step_tick   = (step_cnt_reg >= step_period - 32'd1);

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            step_cnt_reg <= 32'h0000_0000;
        end else if (led_state != LED_RAMP || step_tick) begin
            step_cnt_reg <= 32'h0000_0000;
        end else begin
            step_cnt_reg <= step_cnt_reg + 32'd1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            led_state   <= LED_OFF;
            led_now_reg <= 8'h00;
        end else begin
            case (led_state)
                LED_OFF: begin
                    if (led_code_reg != 8'h00) begin
                        led_state <= LED_RAMP;
                    end
                end
                LED_RAMP: begin
                    // A new code mid-ramp just retargets; direction is picked per step
                    if (led_now_reg == led_code_reg) begin
                        // Zero target ends in shutdown
                        led_state <= (led_code_reg == 8'h00) ? LED_OFF : LED_HOLD;
                    end else if (step_tick) begin
                        if (led_now_reg < led_code_reg) begin
                            led_now_reg <= led_now_reg + 8'h01;
                        end else begin
                            led_now_reg <= led_now_reg - 8'h01;
                        end
                    end
                end
                LED_HOLD: begin
                    if (led_now_reg != led_code_reg) begin
                        led_state <= LED_RAMP;
                    end
                end
                default: begin
                    led_state <= LED_OFF;
                end
            endcase
        end
    end

    // ==========================================
    // Interrupt events
    logic        led_reached;
    logic        led_shut;

    // Both events pulse for one cycle as the ramp meets its target
    assign led_reached = (led_state == LED_RAMP) && (led_now_reg == led_code_reg)
                         && (led_code_reg != 8'h00);
    assign led_shut    = (led_state == LED_RAMP) && (led_now_reg == led_code_reg)
                         && (led_code_reg == 8'h00);
    assign events = {led_shut, led_reached, fault_i[5:0] & ~fault_prev_reg};

    // Only the lower six fault lines raise events; the rest are level-only
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            fault_prev_reg <= 6'h00;
        end else begin
            fault_prev_reg <= fault_i[5:0];
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            irq_stat_reg <= 8'h00;
        end else begin
            // New events win over a clear in the same cycle
            irq_stat_reg <= (irq_stat_reg & ~((wr_i && addr_i == `ADDR_IRQ_CLR) ? wdata_i : 8'h00))
                            | events;
        end
    end

    // Enable mask is not a command register, so the reload leaves it alone
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            irq_en_reg <= 8'h00;
        end else if (wr_i && addr_i == `ADDR_IRQ_EN) begin
            irq_en_reg <= wdata_i;
        end
    end

    // ==========================================
    // Read back
    logic [7:0] rd_mux;

    always_comb begin
        rd_mux = 8'h00;
        case (addr_i)
            8'h00, 8'h01, 8'h02, 8'h03, `ADDR_BOOST_CFG, `ADDR_BB_CFG: begin
                rd_mux = cfg_reg[addr_i[2:0]];
            end
            `ADDR_PULLDOWN: begin
                rd_mux = {4'h0, pulldown_reg};
            end
            `ADDR_LED_CFG: begin
                rd_mux = {5'h00, led_cfg_reg};
            end
            `ADDR_LED_CODE: begin
                rd_mux = led_code_reg;
            end
            `ADDR_FAULT_LO: begin
                rd_mux = fault_i[7:0];
            end
            `ADDR_FAULT_HI: begin
                rd_mux = fault_i[15:8];
            end
            `ADDR_IRQ_STAT: begin
                rd_mux = irq_stat_reg;
            end
            `ADDR_IRQ_EN: begin
                rd_mux = irq_en_reg;
            end
            `ADDR_LED_NOW: begin
                rd_mux = led_now_reg;
            end
            `ADDR_STATE: begin
                rd_mux = {2'b00, led_state != LED_OFF, any_on_reg, 1'b0, pair_sense_i};
            end
            default: begin
                rd_mux = 8'h00;
            end
        endcase
    end

    // Zero outside the read slot, so stale data never lingers on the port
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            rdata_reg <= 8'h00;
        end else if (rd_i) begin
            rdata_reg <= rd_mux;
        end else begin
            rdata_reg <= 8'h00;
        end
    end

    // ==========================================
    // Registered outputs
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            buck_on_o              <= 4'h0;
            switch_node_pulldown_o <= 4'h0;
            reg_set_o              <= '0;
        end else begin
            for (int k = 0; k < 4; k++) begin
                buck_on_o[k]              <= eff_en[k];
                // Pull-down only on a disabled node; a slave copies its master's bit
                switch_node_pulldown_o[k] <= ~eff_en[k] & eff_pd[k];
                reg_set_o[k]              <= eff_set[k];
            end
            reg_set_o[4] <= reg_set_t'(cfg_reg[4][6:0]);
            reg_set_o[5] <= bb_set;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            boost_on_o        <= 1'b0;
            bb_on_o           <= 1'b0;
            bb_switch_d_off_o <= 1'b0;
            en_thresh_low_o   <= 1'b0;
        end else begin
            boost_on_o        <= boost_en;
            bb_on_o           <= bb_en;
            bb_switch_d_off_o <= bb_en & bb_startup_low_i;
            en_thresh_low_o   <= any_on;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            led_current_code_o <= 8'h00;
            led_boost_on_o     <= 1'b0;
            led_hv_mode_o      <= 1'b0;
            irq_o              <= 1'b0;
        end else begin
            led_current_code_o <= led_now_reg;
            led_boost_on_o     <= (led_state != LED_OFF);
            led_hv_mode_o      <= led_cfg_reg[`LED_HV_BIT];
            irq_o              <= |(irq_stat_reg & irq_en_reg);
        end
    end

    // Read data leaves straight from its flop
    assign rdata_o = rdata_reg;
endmodule

// ---- dv/pmic_ctrl_monitor.sv ----
`timescale 1ns/10ps
module pmic_ctrl_monitor #(
    parameter int STEP_CYCLES = 125
) (
    // Clock and reset
    input wire logic                          core_clk_i,
    input wire logic                          reset_i,
    // Register port
    input wire logic [7:0]                    addr_i,
    input wire logic [7:0]                    wdata_i,
    input wire logic                          wr_i,
    input wire logic                          rd_i,
    input wire logic [7:0]                    rdata_o,
    // Pins
    input wire logic [3:0]                    buck_en_pin_i,
    input wire logic                          bb_en_pin_i,
    input wire logic [2:0]                    pair_sense_i,
    input wire logic                          bb_startup_low_i,
    // Controls
    input wire logic [3:0]                    buck_on_o,
    input wire logic                          boost_on_o,
    input wire logic                          bb_on_o,
    input wire logic                          bb_switch_d_off_o,
    input wire pmic_ctrl_pkg::reg_set_t [5:0] reg_set_o,
    input wire logic                          en_thresh_low_o,
    input wire logic [7:0]                    led_current_code_o,
    input wire logic                          led_boost_on_o
);
    import pmic_ctrl_pkg::*;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    // ==========================================
    // Checks
    boost_reg_only_a: assert property ($rose(boost_on_o) |-> $past(wr_i, 2) && $past(addr_i, 2) == 8'h04 && $past(wdata_i[7], 2)) else $error("boost rose without write");
    buck_pin_on_a: assert property (buck_en_pin_i[0] |=> buck_on_o[0]) else $error("buck pin ignored");
    bb_pin_on_a: assert property (bb_en_pin_i |=> bb_on_o) else $error("bb pin ignored");
    thresh_any_on_a: assert property (buck_en_pin_i[0] |-> ##[1:3] en_thresh_low_o) else $error("threshold not lowered");
    thresh_all_off_a: assert property ((buck_on_o == 4'h0 && !bb_on_o && !boost_on_o)[*3] |-> !en_thresh_low_o) else $error("threshold low while off");
    pair_one_a: assert property (pair_sense_i[0][*3] |-> buck_on_o[1] == buck_on_o[0] && reg_set_o[1] == reg_set_o[0]) else $error("slave 2 differs");
    pair_two_a: assert property (pair_sense_i[1][*3] |-> buck_on_o[2] == buck_on_o[1] && reg_set_o[2] == reg_set_o[1]) else $error("slave 3 differs");
    pair_three_a: assert property (pair_sense_i[2][*3] |-> buck_on_o[3] == buck_on_o[2] && reg_set_o[3] == reg_set_o[2]) else $error("slave 4 differs");
    bb_startup_a: assert property (bb_startup_low_i && bb_en_pin_i |=> bb_switch_d_off_o && !reg_set_o[5].burst) else $error("bb start-up not held");
    led_unit_step_a: assert property ($changed(led_current_code_o) |-> (led_current_code_o - $past(led_current_code_o)) == 8'h01 || ($past(led_current_code_o) - led_current_code_o) == 8'h01) else $error("led step not one");
    led_step_rate_a: assert property (STEP_CYCLES > 1 && $changed(led_current_code_o) |=> $stable(led_current_code_o)) else $error("led steps too fast");
    led_active_a: assert property (led_current_code_o != 8'h00 |-> led_boost_on_o) else $error("led code without boost");
    led_shutdown_a: assert property ($fell(led_boost_on_o) |-> led_current_code_o == 8'h00) else $error("boost off above zero");
    rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00) else $error("read data outside slot");
endmodule
bind pmic_ctrl pmic_ctrl_monitor #(.STEP_CYCLES(STEP_CYCLES)) mon (.core_clk_i, .reset_i, .addr_i, .wdata_i, .wr_i,
    .rd_i, .rdata_o, .buck_en_pin_i, .bb_en_pin_i, .pair_sense_i, .bb_startup_low_i, .buck_on_o, .boost_on_o,
    .bb_on_o, .bb_switch_d_off_o, .reg_set_o, .en_thresh_low_o, .led_current_code_o, .led_boost_on_o);

// ---- dv/power_stage_model.sv ----
`timescale 1ns/10ps
module power_stage_model (
    // Clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        reset_i,
    // From the controller and the testbench
    input  wire logic        bb_on_i,
    input  wire logic [15:0] fault_inject_i,
    // Back to the controller
    output logic             bb_startup_low_o,
    output logic [15:0]      fault_o
);
    logic [4:0] ramp_reg;
    // Output voltage climbs for a while after each enable
    always_ff @(posedge core_clk_i) begin
        if (reset_i || !bb_on_i) begin
            ramp_reg <= 5'h00;
        end else if (ramp_reg != 5'h1f) begin
            ramp_reg <= ramp_reg + 5'h01;
        end
    end
    assign bb_startup_low_o = (ramp_reg < 5'h14);
    always_ff @(posedge core_clk_i) begin
        fault_o <= reset_i ? 16'h0000 : fault_inject_i;
    end
endmodule

// ---- dv/pmic_ctrl_tb.sv ----
`timescale 1ns/10ps
module pmic_ctrl_tb;
    import pmic_ctrl_pkg::*;
    logic core_clk_i, reset_i, wr_i, rd_i, bb_en_pin_i, bb_startup_low_i, rd_seen;
    logic [7:0] addr_i, wdata_i, rdata_o, led_current_code_o, v;
    logic [3:0] buck_en_pin_i, buck_on_o, switch_node_pulldown_o;
    logic [2:0] pair_sense_i;
    logic [15:0] fault_i, fault_inject;
    logic boost_on_o, bb_on_o, bb_switch_d_off_o, en_thresh_low_o, led_boost_on_o, led_hv_mode_o, irq_o;
    logic [31:0] seed;
    reg_set_t [5:0] reg_set_o;
    logic [7:0] exp_q[$];
    int n_mismatch, samples_checked;

    pmic_ctrl #(.STEP_CYCLES(2)) DUT (.core_clk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .buck_en_pin_i, .bb_en_pin_i, .pair_sense_i, .bb_startup_low_i, .fault_i, .buck_on_o,
        .switch_node_pulldown_o, .boost_on_o, .bb_on_o, .bb_switch_d_off_o, .reg_set_o, .en_thresh_low_o,
        .led_current_code_o, .led_boost_on_o, .led_hv_mode_o, .irq_o);
    power_stage_model ps (.core_clk_i, .reset_i, .bb_on_i(bb_on_o), .fault_inject_i(fault_inject),
        .bb_startup_low_o(bb_startup_low_i), .fault_o(fault_i));

    initial begin
        core_clk_i = 1'b0;
        forever #4 core_clk_i = ~core_clk_i;
    end
    // ==========================================
    // Helpers
    function logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task wt(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge core_clk_i);
        wr_i <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        exp_q.push_back(e);
        @(posedge core_clk_i);
        rd_i <= 1'b0;
    endtask
    task pins(input logic [3:0] b, input logic bb, input logic [2:0] p);
        @(posedge core_clk_i);
        buck_en_pin_i <= b;
        bb_en_pin_i <= bb;
        pair_sense_i <= p;
    endtask
    task wl(input logic [7:0] t);
        for (int i = 0; i < 300 && led_current_code_o !== t; i++) wt(1);
        chk(led_current_code_o, t);
    endtask
    task stop_test;
        $display("checked=%0d mismatches=%0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Read data stands only in the cycle after the strobe
    always @(posedge core_clk_i) begin
        if (rd_seen) chk(rdata_o, exp_q.pop_front());
        rd_seen <= rd_i;
    end
    initial begin
        #400000;
        n_mismatch++;
        stop_test();
    end
    // ==========================================
    // Tests
    initial begin
        {reset_i, wr_i, rd_i, addr_i, wdata_i, bb_en_pin_i, rd_seen} = {3'b100, 16'h0000, 2'b00};
        {buck_en_pin_i, pair_sense_i, fault_inject, seed} = {7'h00, 16'h0000, 32'd45};
        {n_mismatch, samples_checked} = 0;
        repeat (12) @(posedge core_clk_i);
        reset_i <= 1'b0;
        for (int a = 0; a < 16; a++) rd(a[7:0], 8'h00);
        for (int a = 0; a < 8; a++) begin
            seed = xs(seed);
            v = seed[7:0] & (a == 6 ? 8'h0f : a == 7 ? 8'h07 : 8'h7f);
            wr(a[7:0], v);
            rd(a[7:0], v);
        end
        wr(8'h20, 8'h5a);
        rd(8'h20, 8'h00);
        $display("done: registers");
        wr(8'h06, 8'h05);
        wt(3);
        chk(8'(switch_node_pulldown_o), 8'h05);
        pins(4'h1, 1'b0, 3'h0);
        wt(4);
        chk(8'(boost_on_o), 8'h00);
        chk(8'(buck_on_o), 8'h01);
        chk(8'(en_thresh_low_o), 8'h01);
        wr(8'h04, 8'h9c);
        wt(3);
        chk(8'(boost_on_o), 8'h01);
        chk(8'(reg_set_o[4]), 8'h1c);
        wr(8'h04, 8'h00);
        pins(4'h0, 1'b0, 3'h0);
        wt(4);
        chk(8'(en_thresh_low_o), 8'h00);
        rd(8'h06, 8'h00);
        rd(8'h00, 8'h00);
        $display("done: enables");
        for (int k = 0; k < 3; k++) begin
            wr(k[7:0], 8'h35);
            wr(k[7:0] + 8'h01, 8'h0a);
            pins(4'h2 << k, 1'b0, 3'h1 << k);
            wt(4);
            chk(8'(buck_on_o), 8'h00);
            pins(4'h1 << k, 1'b0, 3'h1 << k);
            wt(4);
            chk(8'(buck_on_o), 8'h03 << k);
            chk(8'(reg_set_o[k + 1]), 8'h35);
            pins(4'h0, 1'b0, 3'h0);
            wt(4);
        end
        $display("done: pairing");
        wr(8'h05, 8'h47);
        pins(4'h0, 1'b1, 3'h0);
        wt(4);
        chk(8'(bb_on_o), 8'h01);
        chk(8'(bb_switch_d_off_o), 8'h01);
        chk(8'(reg_set_o[5]), 8'h07);
        wt(40);
        chk(8'(bb_switch_d_off_o), 8'h00);
        chk(8'(reg_set_o[5]), 8'h47);
        $display("done: buck-boost");
        wr(8'h0d, 8'h01);
        @(posedge core_clk_i);
        fault_inject <= 16'ha503;
        wt(4);
        rd(8'h09, 8'h03);
        rd(8'h0a, 8'ha5);
        rd(8'h0b, 8'h03);
        chk(8'(irq_o), 8'h01);
        wr(8'h0d, 8'h00);
        wt(3);
        chk(8'(irq_o), 8'h00);
        wr(8'h0d, 8'h01);
        wr(8'h0c, 8'h03);
        wt(3);
        rd(8'h0b, 8'h00);
        chk(8'(irq_o), 8'h00);
        $display("done: faults");
        wr(8'h07, 8'h04);
        wt(3);
        chk(8'(led_hv_mode_o), 8'h01);
        chk(8'(led_boost_on_o), 8'h00);
        wr(8'h08, 8'h03);
        wt(3);
        chk(8'(led_boost_on_o), 8'h01);
        wl(8'h03);
        wt(10);
        rd(8'h0e, 8'h03);
        wr(8'h08, 8'h01);
        wl(8'h01);
        wr(8'h07, 8'h01);
        wr(8'h08, 8'h02);
        wt(5);
        chk(led_current_code_o, 8'h01);
        wt(9);
        chk(led_current_code_o, 8'h02);
        wr(8'h08, 8'h00);
        for (int i = 0; i < 300 && led_boost_on_o !== 1'b0; i++) wt(1);
        chk(led_current_code_o, 8'h00);
        chk(8'(led_boost_on_o), 8'h00);
        $display("done: led");
        rd(8'h0b, 8'hc0);
        wt(3);
        stop_test();
    end
endmodule
